// ==== hdl/ltp_code_match.sv ====
`timescale 1ns/100ps
module ltp_code_match
    import ltp_pkg::*;
#(
    parameter int unsigned HIT = 48,
    parameter int unsigned PENALTY = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // received stream
    input wire ltp_bit_t rx_bit,
    // code setting
    input wire logic [7:0] pattern,
    input wire logic [1:0] length,
    // result
    output logic found
);

    ltp_match_t q;
    ltp_match_t d;
    logic [2:0] last;
    logic [2:0] nxt_ph;
    logic exp_bit;

    // phase-locked compare; a leaky score rides out sparse bit errors
    always_comb begin
        d = q;
        last = 3'(length) + 3'h4;
        exp_bit = pattern[last - q.phase];
        nxt_ph = (q.phase == last) ? 3'h0 : q.phase + 3'h1;
        if (rx_bit.stb) begin
            if (rx_bit.dat == exp_bit) begin
                if (q.score != 6'h3f) begin
                    d.score = q.score + 6'h01;
                end
                d.phase = nxt_ph;
            end else if (q.score >= 6'(PENALTY)) begin
                d.score = q.score - 6'(PENALTY);
                d.phase = nxt_ph;
            end else begin
                // phase held: alignment slips one bit while hunting
                d.score = 6'h00;
            end
        end
        d.found = d.score >= 6'(HIT);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign found = q.found;

endmodule

// ==== hdl/ltp_map.svh ====
`ifndef LTP_MAP_SVH
`define LTP_MAP_SVH

// register offsets
`define LTP_A_PATCTL 8'h0a
`define LTP_A_LBCTL 8'h0b
`define LTP_A_LENCTL 8'h0c
`define LTP_A_TXCODE 8'h0d
`define LTP_A_ACTCODE 8'h0e
`define LTP_A_DEACODE 8'h0f
`define LTP_A_ERRCTL 8'h10
`define LTP_A_IMASK 8'h11
`define LTP_A_IEDGE 8'h13
`define LTP_A_LINE_STATUS_PRIMARY 8'h14
`define LTP_A_LINE_STATUS_SECONDARY 8'h15
`define LTP_A_IFLAG 8'h16
`define LTP_A_CNTLO 8'h18
`define LTP_A_CNTHI 8'h19

// field positions
`define LTP_B_CLKSEL 2
`define LTP_B_INV 3
`define LTP_B_ALP 0
`define LTP_B_DLP 1
`define LTP_B_RLP 2
`define LTP_B_AUTO_REMOTE_LOOPBACK_ENABLE 3

// reset values
`define LTP_RST_REG 8'h00
`define LTP_GEN_SEED 20'hfffff

// lock window
`define LTP_LOCK_MAX 7'd6
`define LTP_ERRWIN_RST 7'd64

// timing
`define LTP_CLK_MHZ 200
`define LTP_E1_CODE_MS 30
`define LTP_T1_CODE_MS 40
`define LTP_AUTO_MS 5100
`define LTP_E1_CODE_CYC (`LTP_E1_CODE_MS * `LTP_CLK_MHZ * 1000)
`define LTP_T1_CODE_CYC (`LTP_T1_CODE_MS * `LTP_CLK_MHZ * 1000)
`define LTP_AUTO_CYC (`LTP_AUTO_MS * `LTP_CLK_MHZ * 1000)

`endif

// ==== hdl/ltp_pkg.sv ====
package ltp_pkg;

    typedef enum logic [1:0] {
        LTP_SEQ_NORMAL = 2'b00,
        LTP_SEQ_ONES = 2'b01,
        LTP_SEQ_PRBS = 2'b10,
        LTP_SEQ_CODE = 2'b11
    } ltp_seq_t;

    typedef struct packed {
        logic stb;
        logic dat;
    } ltp_bit_t;

    typedef struct packed {
        logic [2:0] phase;
        logic [5:0] score;
        logic found;
    } ltp_match_t;

    typedef struct packed {
        logic [1:0] txc_s;
        logic [1:0] mck_s;
        logic [1:0] rxc_s;
        logic [1:0] rxd_s;
        logic [1:0] sd_s;
        logic txc_p;
        logic mck_p;
        logic rxc_p;
        logic [7:0] pat_ctl;
        logic [7:0] lb_ctl;
        logic [7:0] len_ctl;
        logic [7:0] tx_code;
        logic [7:0] act_code;
        logic [7:0] dea_code;
        logic [7:0] err_ctl;
        logic [7:0] imask;
        logic [7:0] iedge;
        logic [2:0] flags;
        logic [7:0] rdata;
        ltp_bit_t tx;
        ltp_bit_t rx;
        logic [19:0] gen;
        logic [19:0] chk;
        logic [63:0] errwin;
        logic [6:0] errcnt;
        logic lock;
        logic [2:0] code_ph;
        logic [1:0] cd_st;
        logic [1:0][31:0] cd_tmr;
        logic [1:0][31:0] cd_long;
        logic auto_on;
        logic [15:0] err_count;
    } ltp_state_t;

endpackage

// ==== hdl/ltp_top.sv ====
// Notes on behaviour
// - patterns clock from tx clock, else reference
// - select zero, normal: system data passes
// - field 01 sends continuous ones
// - reference clock with 00 sends zeros
// - 2^20-1 for T1, 2^15-1 for E1
// - field 10 sends sequence, msb first, invertible
// - lock when window errors six or fewer
// - lock changes latch into change flag
// - set flag with enable raises interrupt
// - kind 00 counts sequence errors, 16 bits
// - analog loop returns transmit to receive
// - digital loop returns transmit to receive
// - patterns still override transmit in analog or digital loopback
// - remote loop sends received data back out
// - field 11 repeats loop code unframed
// - transmit code 8 bits, length 5-8
// - activate and deactivate codes matched separately
// - status after code held 30/40 ms
// - edge select chooses rising or all; read clears
// - long activate code starts remote loop
// - long deactivate code ends remote loop
// - clearing auto enable drops automatic loop
`timescale 1ns/100ps
`include "ltp_map.svh"
module ltp_top
    import ltp_pkg::*;
#(
    parameter int unsigned E1_CODE_CYC = `LTP_E1_CODE_CYC,
    parameter int unsigned T1_CODE_CYC = `LTP_T1_CODE_CYC,
    parameter int unsigned AUTO_CYC = `LTP_AUTO_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // line standard, high for T1/J1
    input wire logic t1_mode,
    // system transmit side
    input wire logic sys_tx_data,
    input wire logic line_transmit_clock,
    input wire logic master_ref_clock,
    // recovered line receive side
    input wire logic rx_line_clock,
    input wire logic rx_line_data,
    // outputs
    output ltp_bit_t line_tx,
    output ltp_bit_t rx_out,
    output logic irq
);

    ltp_state_t q;
    ltp_state_t d;
    ltp_seq_t seq;
    logic txc_edge;
    logic mck_edge;
    logic tstb;
    logic clksel;
    logic inv;
    logic rlb;
    logic loop_in;
    ltp_bit_t line_rx;
    ltp_bit_t rs;
    logic [1:0] found;
    logic [2:0] last;
    logic gen_bit;
    logic fb;
    logic chk_b;
    logic pred;
    logic err;
    logic [2:0] cur;
    logic [2:0] prev;
    logic [2:0] ev;
    logic [31:0] code_lim;
    logic [31:0] auto_lim;

    always_comb begin
        d = q;
        d.txc_s = {q.txc_s[0], line_transmit_clock};
        d.mck_s = {q.mck_s[0], master_ref_clock};
        d.rxc_s = {q.rxc_s[0], rx_line_clock};
        d.rxd_s = {q.rxd_s[0], rx_line_data};
        d.sd_s = {q.sd_s[0], sys_tx_data};
        d.txc_p = q.txc_s[1];
        d.mck_p = q.mck_s[1];
        d.rxc_p = q.rxc_s[1];
        txc_edge = q.txc_s[1] & ~q.txc_p;
        mck_edge = q.mck_s[1] & ~q.mck_p;
        seq = ltp_seq_t'(q.pat_ctl[1:0]);
        clksel = q.pat_ctl[`LTP_B_CLKSEL];
        inv = q.pat_ctl[`LTP_B_INV];
        tstb = clksel ? mck_edge : txc_edge;
        rlb = q.lb_ctl[`LTP_B_RLP] | q.auto_on;
        code_lim = t1_mode ? T1_CODE_CYC : E1_CODE_CYC;
        auto_lim = AUTO_CYC;
        line_rx.stb = q.rxc_s[1] & ~q.rxc_p;
        line_rx.dat = q.rxd_s[1];

        // transmit source
        last = 3'(q.len_ctl[1:0]) + 3'h4;
        gen_bit = t1_mode ? q.gen[19] : q.gen[14];
        if (t1_mode && q.gen[18:5] == 14'h0) begin
            gen_bit = 1'b1;
        end
        fb = t1_mode ? (q.gen[19] ^ q.gen[16]) : (q.gen[14] ^ q.gen[13]);
        d.tx.stb = 1'b0;
        if (rlb) begin
            d.tx = line_rx;
        end else if (tstb) begin
            d.tx.stb = 1'b1;
            case (seq)
                LTP_SEQ_NORMAL: begin
                    d.tx.dat = clksel ? 1'b0 : q.sd_s[1];
                end
                LTP_SEQ_ONES: begin
                    d.tx.dat = 1'b1;
                end
                LTP_SEQ_PRBS: begin
                    d.tx.dat = gen_bit ^ inv;
                    d.gen = {q.gen[18:0], fb};
                end
                default: begin
                    d.tx.dat = q.tx_code[last - q.code_ph];
                    d.code_ph = (q.code_ph == last) ? 3'h0 : q.code_ph + 3'h1;
                end
            endcase
        end
        if (seq != LTP_SEQ_CODE) begin
            d.code_ph = 3'h0;
        end

        // receive source
        loop_in = q.lb_ctl[`LTP_B_ALP] | q.lb_ctl[`LTP_B_DLP];
        rs = loop_in ? q.tx : line_rx;
        d.rx = rs;

        // sequence checker, self synchronising
        chk_b = rs.dat ^ inv;
        pred = t1_mode ? (q.chk[19] ^ q.chk[16]) : (q.chk[14] ^ q.chk[13]);
        err = rs.stb & (chk_b != pred);
        if (rs.stb) begin
            d.chk = {q.chk[18:0], chk_b};
            d.errwin = {q.errwin[62:0], err};
            d.errcnt = q.errcnt + 7'(err) - 7'(q.errwin[63]);
            d.lock = d.errcnt <= `LTP_LOCK_MAX;
        end
        if (err && q.err_ctl[1:0] == 2'b00 && q.err_count != 16'hffff) begin
            d.err_count = q.err_count + 16'h0001;
        end

        // loop code status and automatic remote loop
        for (int i = 0; i < 2; i++) begin
            if (found[i]) begin
                if (q.cd_tmr[i] <= code_lim) begin
                    d.cd_tmr[i] = q.cd_tmr[i] + 32'h1;
                end
                if (q.cd_long[i] <= auto_lim) begin
                    d.cd_long[i] = q.cd_long[i] + 32'h1;
                end
            end else begin
                d.cd_tmr[i] = 32'h0;
                d.cd_long[i] = 32'h0;
            end
            d.cd_st[i] = d.cd_tmr[i] > code_lim;
        end
        if (!q.lb_ctl[`LTP_B_AUTO_REMOTE_LOOPBACK_ENABLE]) begin
            d.auto_on = 1'b0;
        end else if (d.cd_long[0] > auto_lim) begin
            d.auto_on = 1'b1;
        end else if (d.cd_long[1] > auto_lim) begin
            d.auto_on = 1'b0;
        end

        // change flags: set wins over clear on read
        cur = {d.cd_st, d.lock};
        prev = {q.cd_st, q.lock};
        ev = (cur & ~prev) | ((cur ^ prev) & q.iedge[2:0]);
        if (reg_rd && reg_addr == `LTP_A_IFLAG) begin
            d.flags = 3'h0;
        end
        d.flags = d.flags | ev;

        // register writes
        if (reg_wr) begin
            if (reg_addr == `LTP_A_PATCTL) begin
                d.pat_ctl = reg_wdata;
            end else if (reg_addr == `LTP_A_LBCTL) begin
                d.lb_ctl = reg_wdata;
            end else if (reg_addr == `LTP_A_LENCTL) begin
                d.len_ctl = reg_wdata;
            end else if (reg_addr == `LTP_A_TXCODE) begin
                d.tx_code = reg_wdata;
            end else if (reg_addr == `LTP_A_ACTCODE) begin
                d.act_code = reg_wdata;
            end else if (reg_addr == `LTP_A_DEACODE) begin
                d.dea_code = reg_wdata;
            end else if (reg_addr == `LTP_A_ERRCTL) begin
                d.err_ctl = reg_wdata;
            end else if (reg_addr == `LTP_A_IMASK) begin
                d.imask = reg_wdata;
            end else if (reg_addr == `LTP_A_IEDGE) begin
                d.iedge = reg_wdata;
            end
        end

        // register reads, data valid only in the next cycle
        d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `LTP_A_PATCTL) begin
                d.rdata = q.pat_ctl;
            end else if (reg_addr == `LTP_A_LBCTL) begin
                d.rdata = q.lb_ctl;
            end else if (reg_addr == `LTP_A_LENCTL) begin
                d.rdata = q.len_ctl;
            end else if (reg_addr == `LTP_A_TXCODE) begin
                d.rdata = q.tx_code;
            end else if (reg_addr == `LTP_A_ACTCODE) begin
                d.rdata = q.act_code;
            end else if (reg_addr == `LTP_A_DEACODE) begin
                d.rdata = q.dea_code;
            end else if (reg_addr == `LTP_A_ERRCTL) begin
                d.rdata = q.err_ctl;
            end else if (reg_addr == `LTP_A_IMASK) begin
                d.rdata = q.imask;
            end else if (reg_addr == `LTP_A_IEDGE) begin
                d.rdata = q.iedge;
            end else if (reg_addr == `LTP_A_LINE_STATUS_PRIMARY) begin
                d.rdata = {5'h00, q.cd_st, q.lock};
            end else if (reg_addr == `LTP_A_LINE_STATUS_SECONDARY) begin
                d.rdata = {7'h00, q.auto_on};
            end else if (reg_addr == `LTP_A_IFLAG) begin
                d.rdata = {5'h00, q.flags};
            end else if (reg_addr == `LTP_A_CNTLO) begin
                d.rdata = q.err_count[7:0];
            end else if (reg_addr == `LTP_A_CNTHI) begin
                d.rdata = q.err_count[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.gen <= `LTP_GEN_SEED;
            // empty window counts as all errors so lock needs real sequence
            q.errwin <= '1;
            q.errcnt <= `LTP_ERRWIN_RST;
        end else begin
            q <= d;
        end
    end

    // activate and deactivate code detectors
    for (genvar g = 0; g < 2; g++) begin : g_code
        ltp_code_match u_match (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .rx_bit(rs),
            .pattern(g == 0 ? q.act_code : q.dea_code),
            .length(g == 0 ? q.len_ctl[3:2] : q.len_ctl[5:4]),
            .found(found[g])
        );
    end

    assign reg_rdata = q.rdata;
    assign line_tx = q.tx;
    assign rx_out = q.rx;
    assign irq = |(q.flags & q.imask[2:0]);

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_ones_out: assert property (
        q.tx.stb && $past(seq == LTP_SEQ_ONES && !rlb) |-> q.tx.dat)
        else $error("all-ones pattern sent a zero");

    a_zeros_out: assert property (
        q.tx.stb && $past(seq == LTP_SEQ_NORMAL && clksel && !rlb) |-> !q.tx.dat)
        else $error("all-zeros pattern sent a one");

    a_clock_pick: assert property (
        !rlb && !clksel && !txc_edge |=> !q.tx.stb)
        else $error("transmit strobe without transmit clock edge");

    a_remote_path: assert property (
        rlb && line_rx.stb |=> q.tx.stb && q.tx.dat == $past(line_rx.dat))
        else $error("remote loop did not return received bit");

    a_lock_rise: assert property (
        $rose(q.lock) |-> q.errcnt <= `LTP_LOCK_MAX)
        else $error("lock set with too many errors");

    a_lock_fall: assert property (
        $fell(q.lock) |-> q.errcnt > `LTP_LOCK_MAX)
        else $error("lock cleared with few errors");

    a_irq_gate: assert property (
        q.flags[0] && q.imask[0] |-> irq)
        else $error("interrupt missing for set flag");

    a_flag_clear: assert property (
        reg_rd && reg_addr == `LTP_A_IFLAG && ev == 3'h0 |=> q.flags == 3'h0)
        else $error("flags not cleared by read");

    a_flag_rise: assert property (
        $rose(q.lock) |-> q.flags[0])
        else $error("lock rise not captured");

    a_err_count: assert property (
        err && q.err_ctl[1:0] == 2'b00 && q.err_count != 16'hffff
        |=> q.err_count == $past(q.err_count) + 16'h0001)
        else $error("sequence error not counted");

    a_auto_drop: assert property (
        !q.lb_ctl[`LTP_B_AUTO_REMOTE_LOOPBACK_ENABLE] |=> !q.auto_on)
        else $error("automatic loop kept after disable");

    a_code_stat: assert property (
        $rose(q.cd_st[0]) |-> $past(found[0]))
        else $error("activate status without detected code");

endmodule

// ==== sim/ltp_far_end.sv ====
`timescale 1ns/100ps
module ltp_far_end (
    // clock
    input wire logic sys_clk,
    // loop code to send while send is high
    input wire logic send,
    input wire logic [7:0] pattern,
    input wire logic [1:0] length,
    // recovered line pins
    output logic rx_line_clock,
    output logic rx_line_data
);
    logic [3:0] tick;
    logic [2:0] idx;

    initial begin
        tick = 4'h0;
        idx = 3'h0;
        rx_line_clock = 1'b0;
        rx_line_data = 1'b0;
    end

    // one bit per 12 cycles, data launched at the falling half so it is stable at the rise
    always @(posedge sys_clk) begin
        if (!send) begin
            tick <= 4'h0;
            rx_line_clock <= 1'b0;
            // line released: clock still, data toggles so no stale value survives
            rx_line_data <= ~rx_line_data;
        end else begin
            tick <= (tick == 4'hb) ? 4'h0 : tick + 4'h1;
            rx_line_clock <= (tick < 4'h6);
            if (tick == 4'h6) begin
                rx_line_data <= pattern[idx];
                idx <= (idx == 3'h0) ? 3'(length) + 3'h4 : idx - 3'h1;
            end
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
    import ltp_pkg::*;
;
    logic sys_clk, resetn, reg_wr, reg_rd, sys_tx_data, t1_mode;
    logic line_transmit_clock, master_ref_clock, rx_line_clock, rx_line_data, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fe_pat, cnt;
    logic [1:0] fe_len;
    logic txc_run, mon_lb, mon_rl, prev_stb, fe_send;
    logic [2:0] tx_cnt;
    logic [3:0] ref_cnt;
    logic [14:0] got;
    ltp_bit_t line_tx, rx_out;
    int num_errors, checked;
    // address, write value, read-back value
    logic [23:0] rows [10] = '{24'h0da5a5, 24'h0e5a5a, 24'h0fc3c3, 24'h0c3c3c, 24'h100303,
        24'h130707, 24'h110000, 24'h12ff00, 24'h14ff00, 24'h0b0000};
    // pattern control, system data, transmit clock running, expected line bit
    logic [10:0] pats [6] = '{{8'h00, 3'h7}, {8'h00, 3'h2}, {8'h01, 3'h3}, {8'h05, 3'h1},
        {8'h04, 3'h6}, {8'h04, 3'h4}};

    ltp_top #(.E1_CODE_CYC(50), .T1_CODE_CYC(80), .AUTO_CYC(400)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t1_mode(t1_mode),
        .sys_tx_data(sys_tx_data), .line_transmit_clock(line_transmit_clock),
        .master_ref_clock(master_ref_clock), .rx_line_clock(rx_line_clock),
        .rx_line_data(rx_line_data), .line_tx(line_tx), .rx_out(rx_out), .irq(irq));

    ltp_far_end far_end (.sys_clk(sys_clk), .send(fe_send), .pattern(fe_pat),
        .length(fe_len), .rx_line_clock(rx_line_clock), .rx_line_data(rx_line_data));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // transmit clock 8 cycles a bit, reference clock 10
    always @(posedge sys_clk) begin
        tx_cnt <= tx_cnt + 3'h1;
        if (txc_run) line_transmit_clock <= tx_cnt[2];
        ref_cnt <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
        master_ref_clock <= (ref_cnt < 4'h5);
    end

    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask

    always @(posedge sys_clk) begin
        prev_stb <= line_tx.stb;
        if (mon_lb && rx_out.stb) chk(prev_stb && rx_out.dat === line_tx.dat, "loop mirror");
        if (mon_rl && line_tx.stb) chk(line_tx.dat === rx_line_data, "remote loop");
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [7:0] d;
        rd(a, d);
        chk((d & m) === v, "register read");
    endtask

    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [7:0] d;
        int n;
        n = 0;
        do begin
            rd(a, d);
            n++;
        end while ((d & m) !== v && n < 4000);
        chk((d & m) === v, "status wait");
        if ((d & m) !== v) give_verdict();
    endtask

    task automatic txbits(input logic e, input int n, input logic en);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge sys_clk);
                #1 k++;
            end while (line_tx.stb !== 1'b1 && k < 200);
            if (line_tx.stb !== 1'b1) begin
                chk(1'b0, "no line bit");
                give_verdict();
            end
            got = {got[13:0], line_tx.dat};
            if (en) chk(line_tx.dat === e, "line bit");
        end
    endtask

    initial begin
        {resetn, reg_wr, reg_rd, sys_tx_data, mon_lb, mon_rl, fe_send, prev_stb} = 8'h00;
        {line_transmit_clock, master_ref_clock, tx_cnt, ref_cnt, got} = 24'h000000;
        {reg_addr, reg_wdata, fe_pat, fe_len} = 26'h0;
        {txc_run, t1_mode} = 2'h3;
        num_errors = 0;
        checked = 0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rc(rows[i][23:16], 8'hff, 8'h00);
            wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], 8'hff, rows[i][7:0]);
        end
        for (int i = 0; i < 6; i++) begin
            txc_run <= pats[i][1];
            sys_tx_data <= pats[i][2];
            wr(8'h0a, pats[i][10:3]);
            txbits(1'b0, 3, 1'b0);
            txbits(pats[i][0], 4, 1'b1);
        end
        // loop code sent through analog loopback into own receiver
        txc_run <= 1'b1;
        wr(8'h0c, 8'h00);
        wr(8'h0d, 8'h16);
        wr(8'h0e, 8'h16);
        wr(8'h13, 8'h00);
        wr(8'h11, 8'h02);
        wr(8'h0b, 8'h01);
        wr(8'h0a, 8'h03);
        mon_lb <= 1'b1;
        txbits(1'b0, 12, 1'b0);
        chk(got[9:0] === {got[4:0], got[4:0]} && got[4:0] != 5'h00 && got[4:0] != 5'h1f, "code");
        poll(8'h14, 8'h02, 8'h02);
        chk(irq === 1'b1, "code irq");
        rc(8'h16, 8'h02, 8'h02);
        rc(8'h16, 8'h02, 8'h00);
        chk(irq === 1'b0, "irq after read");
        // sequence through digital loopback
        wr(8'h0b, 8'h02);
        wr(8'h11, 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h0a, 8'h02);
        poll(8'h14, 8'h01, 8'h01);
        chk(irq === 1'b1, "lock irq");
        rc(8'h16, 8'h01, 8'h01);
        wr(8'h13, 8'h01);
        wr(8'h0a, 8'h01);
        poll(8'h14, 8'h01, 8'h00);
        rc(8'h16, 8'h01, 8'h01);
        rd(8'h18, cnt);
        chk(cnt != 8'h00, "error count");
        // inverted sequence in E1 operation
        t1_mode <= 1'b0;
        wr(8'h0a, 8'h0a);
        poll(8'h14, 8'h01, 8'h01);
        t1_mode <= 1'b1;
        // automatic remote loop driven by the far end
        mon_lb <= 1'b0;
        wr(8'h0a, 8'h00);
        wr(8'h0c, 8'h10);
        wr(8'h0f, 8'h2d);
        wr(8'h0b, 8'h08);
        fe_send <= 1'b1;
        fe_pat <= 8'h16;
        poll(8'h15, 8'h01, 8'h01);
        mon_rl <= 1'b1;
        txbits(1'b0, 6, 1'b0);
        mon_rl <= 1'b0;
        fe_send <= 1'b0;
        repeat (800) @(posedge sys_clk);
        rc(8'h15, 8'h01, 8'h01);
        fe_pat <= 8'h2d;
        fe_len <= 2'h1;
        fe_send <= 1'b1;
        poll(8'h15, 8'h01, 8'h00);
        fe_pat <= 8'h16;
        fe_len <= 2'h0;
        poll(8'h15, 8'h01, 8'h01);
        wr(8'h0b, 8'h00);
        rc(8'h15, 8'h01, 8'h00);
        give_verdict();
    end
endmodule
